//--- logic/ctpwm_regs.vh
// register map, field positions and reset values of the center-aligned pwm timer
`ifndef CTPWM_REGS_VH
`define CTPWM_REGS_VH

// byte addresses of the registers on the axi4-lite bus
`define CTPWM_SC_ADDR      12'h000
`define CTPWM_CNTH_ADDR    12'h004
`define CTPWM_CNTL_ADDR    12'h008
`define CTPWM_MODH_ADDR    12'h00c
`define CTPWM_MODL_ADDR    12'h010
`define CTPWM_CH0_CTL_ADDR 12'h014
`define CTPWM_CH0_VH_ADDR  12'h018
`define CTPWM_CH0_VL_ADDR  12'h01c
`define CTPWM_CH_STRIDE    12'h00c
`define CTPWM_ADDR_W       12

// status and control register fields
`define CTPWM_PS_LSB       0
`define CTPWM_PS_MSB       2
`define CTPWM_CLOCK_SOURCE_SELECT_LSB     3
`define CTPWM_CLOCK_SOURCE_SELECT_MSB     4
`define CTPWM_CPWMS_BIT    5

// channel control fields
`define CTPWM_CH_PWMEN_BIT 0
`define CTPWM_CH_ACTLO_BIT 1

// reset values
`define CTPWM_SC_RST       8'h00
`define CTPWM_CNT_RST      16'h0000
`define CTPWM_MOD_RST      16'hffff
`define CTPWM_CV_RST       16'h0000
`define CTPWM_CTL_RST      8'h00
`define CTPWM_PSC_RST      7'h00

// counter constants
`define CTPWM_ONE          16'h0001
`define CTPWM_ZERO         16'h0000
`define CTPWM_PSC_ONE      7'h01
`define CTPWM_CLOCK_SOURCE_SELECT_OFF     2'h0

// axi responses
`define CTPWM_RESP_OKAY    2'h0
`define CTPWM_RESP_SLVERR  2'h2

`endif

//--- logic/ctpwm_top.v
// center-aligned pwm timer with an axi4-lite register slave and two pwm channels
`timescale 1ns/100ps
`include "ctpwm_regs.vh"

// What this block does
// RULE1 - center mode counts up to modulo, then down
// RULE2 - period starts at modulo minus one to modulo
// RULE3 - zero and modulo held once, period twice modulo
// RULE4 - hidden output flop per channel, reset low
// RULE5 - output flop changes only on compare match; code also changes it at edge-mode period start, on negative or full values
// RULE6 - reset clears sixteen-bit counter to zero
// RULE7 - start from zero count is mid-period
// RULE8 - channel value equal modulo gives full duty
// RULE9 - modulo minus one keeps proportional duty
// RULE10 - negative channel values give zero duty
// RULE11 - zero to nonzero applies at period start
// RULE12 - prescaler divider kept when selection changes
// RULE13 - prescale code one divides by two
// RULE14 - edge mode zero-to-nonzero may lag period
// RULE15 - software writes negative value for zero duty
// RULE16 - software may write modulo plus one
// RULE17 - software may halve prescale, double values
// RULE18 - clock select zero stops, nonzero runs counter
// RULE19 - any counter write clears counter
// RULE20 - other prescale codes are powers of two
// RULE21 - full sixteen-bit compare, byte-wide registers
module ctpwm_top (
	aclk,
	aresetn,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	ext_clk,
	pwm_out
);
	localparam NCH = 2;                           // number of channels

	input  wire                     aclk;          // timer and bus clock
	input  wire                     aresetn;       // synchronous reset, active low
	input  wire [`CTPWM_ADDR_W-1:0] s_axi_awaddr;
	input  wire                     s_axi_awvalid;
	output wire                     s_axi_awready;
	input  wire [31:0]              s_axi_wdata;
	input  wire [3:0]               s_axi_wstrb;
	input  wire                     s_axi_wvalid;
	output wire                     s_axi_wready;
	output reg  [1:0]               s_axi_bresp;
	output reg                      s_axi_bvalid;
	input  wire                     s_axi_bready;
	input  wire [`CTPWM_ADDR_W-1:0] s_axi_araddr;
	input  wire                     s_axi_arvalid;
	output wire                     s_axi_arready;
	output reg  [31:0]              s_axi_rdata;
	output reg  [1:0]               s_axi_rresp;
	output reg                      s_axi_rvalid;
	input  wire                     s_axi_rready;
	input  wire                     ext_clk;       // external count source pin
	output wire [NCH-1:0]           pwm_out;       // channel output pins

	// write address and data latches, taken in either order
	reg  [`CTPWM_ADDR_W-1:0] aw_addr_r;
	reg                      aw_have_r;
	reg  [31:0]              w_data_r;
	reg  [3:0]               w_strb_r;
	reg                      w_have_r;
	wire                     wr_go;                // both halves present, response free

	// registers
	reg  [7:0]         sc_r;                       // prescale, clock source, center mode
	reg  [15:0]        cnt_r;                      // counter value
	reg                down_r;                     // counting direction, high = down
	reg  [15:0]        mod_r;                      // modulo value
	reg  [7:0]         chctl_r [0:NCH-1];          // channel control
	reg  [15:0]        cv_r    [0:NCH-1];          // channel compare value
	reg  [NCH-1:0]     outff_r;                    // hidden output flops, not readable
	reg  [6:0]         psc_r;                      // prescaler divider state
	// external clock pin synchroniser and edge detect
	reg                ext_s1_r;
	reg                ext_s2_r;
	reg                ext_s3_r;

	wire [2:0]         ps_sel   = sc_r[`CTPWM_PS_MSB:`CTPWM_PS_LSB];
	wire [1:0]         clock_source_select     = sc_r[`CTPWM_CLOCK_SOURCE_SELECT_MSB:`CTPWM_CLOCK_SOURCE_SELECT_LSB];
	wire               cpwm     = sc_r[`CTPWM_CPWMS_BIT];
	wire               cnt_wr;                     // software write to counter bytes
	wire               src_tick;                   // selected source clock edge
	wire               tick;                       // divided counter enable
	wire [6:0]         psc_mask;
	wire               at_mod   = (cnt_r == mod_r);
	wire               at_zero  = (cnt_r == `CTPWM_ZERO);
	reg  [15:0]        cnt_nxt;
	reg                down_nxt;
	assign s_axi_awready = ~aw_have_r;
	assign s_axi_wready  = ~w_have_r;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_go         = aw_have_r & w_have_r & ~s_axi_bvalid;
	// latch write address and data separately; each waits for its partner
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= {`CTPWM_ADDR_W{1'b0}};
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_have_r) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid && !w_have_r) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// only lane 0 carries data; a write with lane 0 off stores nothing
	wire wr_en = wr_go & w_strb_r[0];
	assign cnt_wr = wr_en && ((aw_addr_r == `CTPWM_CNTH_ADDR) ||
		(aw_addr_r == `CTPWM_CNTL_ADDR)); // RULE19

	// decode a channel address: returns 1 when addr hits channel ch register off
	function hit;
		input [`CTPWM_ADDR_W-1:0] addr;
		input integer             ch;
		input [`CTPWM_ADDR_W-1:0] off;
		begin
			hit = (addr == off + ch[`CTPWM_ADDR_W-1:0] * `CTPWM_CH_STRIDE);
		end
	endfunction

	// write response, unmapped addresses answer slverr
	reg wr_ok;
	integer k;
	always @* begin
		wr_ok = 1'b0;
		if (aw_addr_r == `CTPWM_SC_ADDR || aw_addr_r == `CTPWM_CNTH_ADDR ||
			aw_addr_r == `CTPWM_CNTL_ADDR || aw_addr_r == `CTPWM_MODH_ADDR ||
			aw_addr_r == `CTPWM_MODL_ADDR) begin
			wr_ok = 1'b1;
		end
		for (k = 0; k < NCH; k = k + 1) begin
			if (hit(aw_addr_r, k, `CTPWM_CH0_CTL_ADDR) || hit(aw_addr_r, k, `CTPWM_CH0_VH_ADDR) ||
				hit(aw_addr_r, k, `CTPWM_CH0_VL_ADDR)) begin
				wr_ok = 1'b1;
			end
		end
	end

	// register writes; byte-wide halves of the sixteen-bit values
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			sc_r  <= `CTPWM_SC_RST;
			mod_r <= `CTPWM_MOD_RST;
			for (i = 0; i < NCH; i = i + 1) begin
				chctl_r[i] <= `CTPWM_CTL_RST;
				cv_r[i]    <= `CTPWM_CV_RST;
			end
		end else if (wr_en) begin
			if (aw_addr_r == `CTPWM_SC_ADDR) begin
				sc_r <= w_data_r[7:0]; // RULE18
			end else if (aw_addr_r == `CTPWM_MODH_ADDR) begin
				mod_r[15:8] <= w_data_r[7:0]; // RULE21
			end else if (aw_addr_r == `CTPWM_MODL_ADDR) begin
				mod_r[7:0] <= w_data_r[7:0]; // RULE21
			end
			for (i = 0; i < NCH; i = i + 1) begin
				if (hit(aw_addr_r, i, `CTPWM_CH0_CTL_ADDR)) begin
					chctl_r[i] <= w_data_r[7:0];
				end else if (hit(aw_addr_r, i, `CTPWM_CH0_VH_ADDR)) begin
					cv_r[i][15:8] <= w_data_r[7:0]; // RULE21
				end else if (hit(aw_addr_r, i, `CTPWM_CH0_VL_ADDR)) begin
					cv_r[i][7:0] <= w_data_r[7:0]; // RULE21
				end
			end
		end
	end

	// write response channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CTPWM_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? `CTPWM_RESP_OKAY : `CTPWM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read channel; output flops are deliberately not in the read map
	reg [31:0] rd_val;
	reg        rd_ok;
	integer j;
	always @* begin
		rd_val = 32'h00000000;
		rd_ok  = 1'b1;
		if (s_axi_araddr == `CTPWM_SC_ADDR) begin
			rd_val[7:0] = sc_r;
		end else if (s_axi_araddr == `CTPWM_CNTH_ADDR) begin
			rd_val[7:0] = cnt_r[15:8];
		end else if (s_axi_araddr == `CTPWM_CNTL_ADDR) begin
			rd_val[7:0] = cnt_r[7:0];
		end else if (s_axi_araddr == `CTPWM_MODH_ADDR) begin
			rd_val[7:0] = mod_r[15:8];
		end else if (s_axi_araddr == `CTPWM_MODL_ADDR) begin
			rd_val[7:0] = mod_r[7:0];
		end else begin
			rd_ok = 1'b0;
		end
		for (j = 0; j < NCH; j = j + 1) begin
			if (hit(s_axi_araddr, j, `CTPWM_CH0_CTL_ADDR)) begin
				rd_val[7:0] = chctl_r[j];
				rd_ok       = 1'b1;
			end else if (hit(s_axi_araddr, j, `CTPWM_CH0_VH_ADDR)) begin
				rd_val[7:0] = cv_r[j][15:8];
				rd_ok       = 1'b1;
			end else if (hit(s_axi_araddr, j, `CTPWM_CH0_VL_ADDR)) begin
				rd_val[7:0] = cv_r[j][7:0];
				rd_ok       = 1'b1;
			end
		end
	end // RULE4

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `CTPWM_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_ok ? `CTPWM_RESP_OKAY : `CTPWM_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// external clock pin: two flops, then a third for the rising edge
	always @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_clk;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end

	// source 1 = bus clock, 2 and 3 = external pin edge, 0 = stopped
	assign src_tick = (clock_source_select == `CTPWM_CLOCK_SOURCE_SELECT_OFF) ? 1'b0 : // RULE18
		(clock_source_select[1] ? (ext_s2_r & ~ext_s3_r) : 1'b1);

	// free-running divider, kept on a select change: first tick may come early or late
	assign psc_mask = (`CTPWM_PSC_ONE << ps_sel) - `CTPWM_PSC_ONE; // RULE13 RULE20
	assign tick     = src_tick && ((psc_r & psc_mask) == psc_mask);
	always @(posedge aclk) begin
		if (!aresetn) begin
			psc_r <= `CTPWM_PSC_RST;
		end else if (src_tick) begin
			psc_r <= psc_r + `CTPWM_PSC_ONE; // RULE12
		end
	end

	// next count: center mode turns at modulo and at zero, edge mode wraps
	always @* begin
		cnt_nxt  = cnt_r;
		down_nxt = down_r;
		if (cpwm) begin
			if (!down_r) begin
				if (at_mod) begin
					cnt_nxt  = cnt_r - `CTPWM_ONE; // RULE1 RULE3
					down_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r + `CTPWM_ONE;
				end
			end else begin
				if (at_zero) begin
					cnt_nxt  = cnt_r + `CTPWM_ONE; // RULE1 RULE3
					down_nxt = 1'b0;
				end else begin
					cnt_nxt = cnt_r - `CTPWM_ONE;
				end
			end
		end else begin
			down_nxt = 1'b0;
			cnt_nxt  = at_mod ? `CTPWM_ZERO : cnt_r + `CTPWM_ONE;
		end
	end

	// counter; reset and any counter write clear the count
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r  <= `CTPWM_CNT_RST; // RULE6 RULE7
			down_r <= 1'b0;
		end else if (cnt_wr) begin
			cnt_r <= `CTPWM_CNT_RST; // RULE19
		end else if (tick) begin
			cnt_r  <= cnt_nxt;
			down_r <= down_nxt;
		end
	end

	// period start in center mode: count steps from modulo minus one to modulo
	wire period_start = cpwm ? (tick && !down_r && cnt_nxt == mod_r && !at_mod) : // RULE2
		(tick && at_mod);

	// per channel: compare value latched at period start, output flop
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : gch
			reg  [15:0] cva_r;                      // active compare value
			wire        neg  = cva_r[15];           // negative value means 0% duty
			wire        full = (cva_r >= mod_r);    // non-negative value at or above modulo means 100% duty
			wire        pwm_en = chctl_r[g][`CTPWM_CH_PWMEN_BIT];
			wire        match = tick && !neg && (cnt_nxt == cva_r); // RULE21
			reg         ff_nxt;
			always @* begin
				ff_nxt = outff_r[g];
				if (tick && pwm_en && neg) begin
					ff_nxt = 1'b0; // RULE10
				end else if (tick && pwm_en && full) begin
					ff_nxt = 1'b1; // RULE8
				end else if (match) begin
					// center mode: active inside the window, edge mode: clear at match
					ff_nxt = cpwm ? down_nxt : 1'b0; // RULE5 RULE9
				end else if (period_start && !cpwm && pwm_en && cva_r != `CTPWM_ZERO) begin
					ff_nxt = 1'b1;
				end
			end
			always @(posedge aclk) begin
				if (!aresetn) begin
					cva_r      <= `CTPWM_CV_RST;
					outff_r[g] <= 1'b0; // RULE4
				end else begin
					outff_r[g] <= ff_nxt;
					// new duty only at a period boundary while enabled; a disabled channel loads it every cycle
					if (period_start || !pwm_en) begin
						cva_r <= cv_r[g]; // RULE11 RULE14
					end
				end
			end
			assign pwm_out[g] = outff_r[g] ^ chctl_r[g][`CTPWM_CH_ACTLO_BIT];
		end
	endgenerate
endmodule

//--- tb/ctpwm_chk_sva.sv
// concurrent checks on the bus and pin ports of the pwm timer
`timescale 1ns/100ps
`include "ctpwm_regs.vh"
module ctpwm_chk (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic [11:0] s_axi_araddr,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0]  s_axi_rresp,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [1:0]  pwm_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// hidden output flops leave reset low
	out_reset_a: assert property ($rose(aresetn) |-> pwm_out == 2'h0)
		else $error("pin not low after reset");
	// responses wait for the master
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while data pending");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	// nothing is mapped past the last channel value register
	unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h028
		|=> s_axi_rresp == `CTPWM_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	byte_read_a: assert property (s_axi_rvalid && s_axi_rresp == `CTPWM_RESP_OKAY
		|-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");

	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rresp == `CTPWM_RESP_SLVERR);
	cover property ($rose(pwm_out[0]));
	cover property (pwm_out[1] [*8]);
endmodule
bind ctpwm_top ctpwm_chk ctpwm_chk_i (.*);

//--- tb/ctpwm_load.sv
// load model on the pwm pins: tallies on-time per pin and rising edges of pin 0
`timescale 1ns/100ps
module ctpwm_load (
	input  logic        aclk,
	input  logic        clr,
	input  logic [1:0]  pin,
	output logic [15:0] hi0,
	output logic [15:0] hi1,
	output logic [15:0] edges
);
	logic last_r; // pin 0 one cycle back, for edge detection

	// the load only watches; clear restarts a measurement window
	always @(posedge aclk) begin
		last_r <= pin[0];
		if (clr) begin
			hi0   <= 16'h0;
			hi1   <= 16'h0;
			edges <= 16'h0;
		end else begin
			hi0   <= hi0 + pin[0];
			hi1   <= hi1 + pin[1];
			edges <= edges + (pin[0] & ~last_r);
		end
	end
endmodule

//--- tb/ctpwm_top_bench.sv
// self-checking bench for the pwm timer: bus access, duty, period and clock select
`timescale 1ns/100ps
`include "ctpwm_regs.vh"
module ctpwm_top_bench;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b0;
	logic        ext_clk = 1'b0;      // external count source, low unless a test pulses it
	logic [1:0]  pwm_out;
	logic        clr = 1'b1;          // holds the load tallies at zero
	logic [15:0] hi0, hi1, edges;
	logic [1:0]  bresp_seen;
	logic [31:0] d;
	logic [1:0]  r;
	logic [87:0] rows [0:5];          // sc, ch0 value, ch1 value, on0, on1, edges0
	integer      bad_count = 0;
	integer      total_checks = 0;
	integer      cyc = 0;
	integer      i;
	integer      lag = 0;             // cycles the master waits before raising bready or rready

	ctpwm_top ctpwm_top_i (.*);
	ctpwm_load ctpwm_load_i (.aclk(aclk), .clr(clr), .pin(pwm_out), .hi0(hi0), .hi1(hi1),
		.edges(edges));

	always #20 aclk = ~aclk;

	task summarize;
		begin
			$display("checks %0d mismatches %0d", total_checks, bad_count);
			if (bad_count == 0 && total_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	// ceiling is several times the expected run length
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			summarize();
		end
	end

	task chk(input string n, input [31:0] e, input [31:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				$display("wrong value %s expected %h seen %h", n, e, g);
				bad_count = bad_count + 1;
			end
		end
	endtask

	// handshake state is sampled mid-cycle, so it equals what the next edge sees
	task wr(input [11:0] a, input [31:0] v);
		reg ta, tw, tb;
		integer n;
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= (lag == 0);
			tb = 1'b0;
			n = 0;
			while (!tb) begin
				@(negedge aclk);
				ta = s_axi_awvalid && s_axi_awready;
				tw = s_axi_wvalid && s_axi_wready;
				tb = s_axi_bvalid && s_axi_bready;
				bresp_seen = s_axi_bresp;
				@(posedge aclk);
				n = n + 1;
				if (ta) s_axi_awvalid <= 1'b0;
				if (tw) s_axi_wvalid <= 1'b0;
				if (tb) s_axi_bready <= 1'b0;
				else if (n >= lag) s_axi_bready <= 1'b1;
			end
		end
	endtask

	task rd(input [11:0] a, output [31:0] v, output [1:0] rs);
		reg ta, tr;
		integer n;
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= (lag == 0);
			tr = 1'b0;
			n = 0;
			while (!tr) begin
				@(negedge aclk);
				ta = s_axi_arvalid && s_axi_arready;
				tr = s_axi_rvalid && s_axi_rready;
				v = s_axi_rdata;
				rs = s_axi_rresp;
				@(posedge aclk);
				n = n + 1;
				if (ta) s_axi_arvalid <= 1'b0;
				if (tr) s_axi_rready <= 1'b0;
				else if (n >= lag) s_axi_rready <= 1'b1;
			end
		end
	endtask

	// a channel value is two byte registers, high then low
	task setv(input integer ch, input [15:0] v);
		begin
			wr(`CTPWM_CH0_VH_ADDR + `CTPWM_CH_STRIDE * ch, {24'h0, v[15:8]});
			wr(`CTPWM_CH0_VL_ADDR + `CTPWM_CH_STRIDE * ch, {24'h0, v[7:0]});
		end
	endtask

	// 64 cycles span whole periods for every prescale used, so tallies are exact
	task measure;
		begin
			@(posedge aclk);
			clr <= 1'b0;
			repeat (64) @(posedge aclk);
			@(negedge aclk);
			clr <= 1'b1;
		end
	endtask

	initial begin
		rows[0] = {8'h28, 16'h0002, 16'h0004, 16'd32, 16'd64, 16'd8};
		rows[1] = {8'h28, 16'h0003, 16'h0005, 16'd48, 16'd64, 16'd8};
		rows[2] = {8'h28, 16'h8000, 16'hffff, 16'd0, 16'd0, 16'd0};
		rows[3] = {8'h29, 16'h0002, 16'h0004, 16'd32, 16'd64, 16'd4};
		rows[4] = {8'h2a, 16'h0002, 16'h0004, 16'd32, 16'd64, 16'd2};
		rows[5] = {8'h2b, 16'h0002, 16'h0004, 16'd32, 16'd64, 16'd1};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		wr(`CTPWM_MODH_ADDR, 32'h0);
		wr(`CTPWM_MODL_ADDR, 32'h4);
		wr(`CTPWM_CH0_CTL_ADDR, 32'h1);
		wr(`CTPWM_CH0_CTL_ADDR + `CTPWM_CH_STRIDE, 32'h1);
		for (i = 0; i < 6; i = i + 1) begin
			setv(0, rows[i][79:64]);
			setv(1, rows[i][63:48]);
			wr(`CTPWM_SC_ADDR, {24'h0, rows[i][87:80]});
			repeat (160) @(posedge aclk);
			measure;
			chk("pin0 on-time", {16'h0, rows[i][47:32]}, {16'h0, hi0});
			chk("pin1 on-time", {16'h0, rows[i][31:16]}, {16'h0, hi1});
			chk("pin0 periods", {16'h0, rows[i][15:0]}, {16'h0, edges});
		end
		// stop the clock, clear the count and see that it stays cleared
		wr(`CTPWM_SC_ADDR, 32'h20);
		wr(`CTPWM_CNTL_ADDR, 32'h55);
		repeat (20) @(posedge aclk);
		rd(`CTPWM_CNTH_ADDR, d, r);
		chk("count high", 32'h0, d);
		rd(`CTPWM_CNTL_ADDR, d, r);
		chk("count low", 32'h0, d);
		measure;
		chk("stopped periods", 32'h0, {16'h0, edges});
		wr(`CTPWM_SC_ADDR, 32'h28);
		repeat (160) @(posedge aclk);
		measure;
		chk("restarted periods", 32'h8, {16'h0, edges});
		// prescale halved, modulo and value doubled: same rate and duty as div-by-two
		wr(`CTPWM_MODL_ADDR, 32'h8);
		setv(0, 16'h0004);
		repeat (160) @(posedge aclk);
		measure;
		chk("doubled on-time", 32'd32, {16'h0, hi0});
		chk("doubled periods", 32'd4, {16'h0, edges});
		// edge mode: zero duty first, then a nonzero value takes over at a wrap
		wr(`CTPWM_SC_ADDR, 32'h20);
		wr(`CTPWM_CNTL_ADDR, 32'h0);
		wr(`CTPWM_MODL_ADDR, 32'h3);
		setv(0, 16'h0000);
		wr(`CTPWM_SC_ADDR, 32'h08);
		repeat (40) @(posedge aclk);
		measure;
		chk("edge zero on-time", 32'h0, {16'h0, hi0});
		setv(0, 16'h0002);
		repeat (40) @(posedge aclk);
		measure;
		chk("edge on-time", 32'd32, {16'h0, hi0});
		chk("edge periods", 32'd16, {16'h0, edges});
		chk("above modulo on-time", 32'd64, {16'h0, hi1});
		// active-low control inverts the pin
		wr(`CTPWM_CH0_CTL_ADDR + `CTPWM_CH_STRIDE, 32'h3);
		measure;
		chk("inverted pin", 32'h0, {16'h0, hi1});
		// lane 0 off stores nothing; responses also wait for a late master
		@(posedge aclk);
		lag = 4;
		s_axi_wstrb <= 4'he;
		wr(`CTPWM_MODL_ADDR, 32'h55);
		s_axi_wstrb <= 4'hf;
		rd(`CTPWM_MODL_ADDR, d, r);
		lag = 0;
		chk("masked write", 32'h3, d);
		chk("masked response", {30'h0, `CTPWM_RESP_OKAY}, {30'h0, bresp_seen});
		// external pin source: each rising edge of the pin is one count
		wr(`CTPWM_SC_ADDR, 32'h20);
		wr(`CTPWM_CNTL_ADDR, 32'h0);
		wr(`CTPWM_SC_ADDR, 32'h10);
		repeat (6) begin
			repeat (3) @(posedge aclk);
			ext_clk <= ~ext_clk;
		end
		repeat (6) @(posedge aclk);
		rd(`CTPWM_CNTL_ADDR, d, r);
		chk("pin source count", 32'h3, d);
		wr(12'hff0, 32'h0);
		chk("unmapped write", {30'h0, `CTPWM_RESP_SLVERR}, {30'h0, bresp_seen});
		// second reset in mid-run brings back the reset state
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("pins after reset", 32'h0, {30'h0, pwm_out});
		rd(`CTPWM_SC_ADDR, d, r);
		chk("control reset", 32'h0, d);
		rd(`CTPWM_CNTL_ADDR, d, r);
		chk("count reset", 32'h0, d);
		rd(`CTPWM_MODL_ADDR, d, r);
		chk("modulo reset", 32'hff, d);
		rd(`CTPWM_CH0_VL_ADDR, d, r);
		chk("value reset", 32'h0, d);
		rd(12'hffc, d, r);
		chk("unmapped read", {30'h0, `CTPWM_RESP_SLVERR}, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		summarize();
	end
endmodule
